// File: common/gear_clutch_pkg.sv
`default_nettype none
package gear_clutch_pkg;
    // register offsets (word addresses on the plain register port)
    localparam logic [3:0] REG_CTRL     = 4'h0; // mode, clutch command, direction, clutch type
    localparam logic [3:0] REG_IN_TEETH = 4'h1; // input_tooth_count staging
    localparam logic [3:0] REG_OUT_TEETH= 4'h2; // output tooth count staging
    localparam logic [3:0] REG_SMOOTH   = 4'h3; // smoothing method and parameter
    localparam logic [3:0] REG_AXES     = 4'h4; // configured axis count
    localparam logic [3:0] REG_STATUS   = 4'h5; // clutch status, smoothing done, mode
    localparam logic [3:0] REG_CUR_NUM  = 4'h6; // active output tooth count
    localparam logic [3:0] REG_CUR_DEN  = 4'h7; // active input tooth count
    // control field positions
    localparam int CTRL_VIRTUAL = 0;
    localparam int CTRL_CLUTCH  = 1;
    localparam int CTRL_REVERSE = 2;
    localparam int CTRL_SMOOTH  = 3;
    // smoothing methods
    localparam logic [1:0] SM_TIME   = 2'h0;
    localparam logic [1:0] SM_EXP    = 2'h1;
    localparam logic [1:0] SM_LINEAR = 2'h2;
    // reset values
    localparam logic [15:0] TEETH_RST  = 16'h0001;
    localparam logic [5:0]  AXES_RST   = 6'h01;
    localparam logic [15:0] SMOOTH_RST = 16'h0004;
    // operation cycle periods in us and derived counts at 100 MHz
    localparam int CLK_NS    = 10;
    localparam int CYC1_NS   = 440;
    localparam int CYC2_NS   = 880;
    localparam int CYC3_NS   = 1770;
    localparam int CYC4_NS   = 3550;
    localparam int CYC1_CLKS = CYC1_NS * 1000 / CLK_NS;
    localparam int CYC2_CLKS = CYC2_NS * 1000 / CLK_NS;
    localparam int CYC3_CLKS = CYC3_NS * 1000 / CLK_NS;
    localparam int CYC4_CLKS = CYC4_NS * 1000 / CLK_NS;
    // axis count thresholds
    localparam logic [5:0] AXES_T1 = 6'h04;
    localparam logic [5:0] AXES_T2 = 6'h0C;
    localparam logic [5:0] AXES_T3 = 6'h1C;
    // pulse word carried through the buffer
    typedef struct packed {
        logic signed [31:0] pulses;
    } pulse_s;
    // register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } reg_req_s;
endpackage
`default_nettype wire

// File: rtl/gear_clutch.sv
// Local design decisions: the address map and the strobed register port.
`default_nettype none
module gear_clutch #(
    parameter int FIFO_DEPTH = 16,
    parameter int CYC4_CLKS  = gear_clutch_pkg::CYC4_CLKS
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic [3:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic [31:0]       reg_rdata,
    input  wire logic signed [31:0] drive_pulses,
    input  wire logic         drive_rebase,
    output logic signed [31:0] out_pulses,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic              cycle_tick,
    output logic              clutch_status,
    output logic              smooth_done
);
    initial begin
        if (FIFO_DEPTH < 2 || CYC4_CLKS < 4) $error("gear_clutch: bad parameter");
    end
    // staging registers written by software
    logic [3:0]  ctrl_q, ctrl_d;
    logic [15:0] in_t_q, in_t_d, out_t_q, out_t_d, smooth_q, smooth_d;
    logic [1:0]  smeth_q, smeth_d;
    logic [5:0]  axes_q, axes_d;
    logic [31:0] rdata_d;
    // active values captured at entry / per cycle
    logic [15:0] den_q, den_d, num_q, num_d;
    logic        rev_q, rev_d, virt_q, virt_d, cmd_q, cmd_d, stype_q, stype_d;
    logic [1:0]  am_q, am_d;
    logic [15:0] aslip_q, aslip_d;
    logic [31:0] tmr_q, tmr_d, period;
    logic        tick;
    logic signed [47:0] acc_q, acc_d, prod, quot, rem;
    logic signed [31:0] geared;
    logic signed [31:0] slip_q, slip_d, clout;
    logic        clst_q, clst_d, sdone_q, sdone_d;
    logic        fin_ready;
    logic signed [31:0] fout;
    logic        fvalid;

    // period by axis count
    function automatic logic [31:0] cycle_clks(input logic [5:0] n);
        if (n <= gear_clutch_pkg::AXES_T1) return 32'(gear_clutch_pkg::CYC1_CLKS);
        else if (n <= gear_clutch_pkg::AXES_T2) return 32'(gear_clutch_pkg::CYC2_CLKS);
        else if (n <= gear_clutch_pkg::AXES_T3) return 32'(gear_clutch_pkg::CYC3_CLKS);
        else return 32'(CYC4_CLKS);
    endfunction
    // zero count is refused and keeps the previous value
    function automatic logic [15:0] teeth_ok(input logic [15:0] v, input logic [15:0] old);
        return (v == 16'h0000) ? old : v;
    endfunction

    // register writes and read data
    always_comb begin
        ctrl_d   = ctrl_q;
        in_t_d   = in_t_q;
        out_t_d  = out_t_q;
        smooth_d = smooth_q;
        smeth_d  = smeth_q;
        axes_d   = axes_q;
        rdata_d  = 32'h0000_0000;
        if (reg_wr) begin
            case (reg_addr)
                gear_clutch_pkg::REG_CTRL:      ctrl_d = reg_wdata[3:0];
                gear_clutch_pkg::REG_IN_TEETH:  in_t_d = teeth_ok(reg_wdata[15:0], in_t_q);
                gear_clutch_pkg::REG_OUT_TEETH: out_t_d = teeth_ok(reg_wdata[15:0], out_t_q);
                gear_clutch_pkg::REG_SMOOTH: begin
                    smooth_d = (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
                    smeth_d  = (reg_wdata[17:16] == 2'h3) ? smeth_q : reg_wdata[17:16];
                end
                gear_clutch_pkg::REG_AXES: axes_d = (reg_wdata[5:0] == 6'h00) ? axes_q : reg_wdata[5:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                gear_clutch_pkg::REG_CTRL:      rdata_d = {28'h0, ctrl_q};
                gear_clutch_pkg::REG_IN_TEETH:  rdata_d = {16'h0, in_t_q};
                gear_clutch_pkg::REG_OUT_TEETH: rdata_d = {16'h0, out_t_q};
                gear_clutch_pkg::REG_SMOOTH:    rdata_d = {14'h0, smeth_q, smooth_q};
                gear_clutch_pkg::REG_AXES:      rdata_d = {26'h0, axes_q};
                gear_clutch_pkg::REG_STATUS:    rdata_d = {29'h0, virt_q, sdone_q, clst_q};
                gear_clutch_pkg::REG_CUR_NUM:   rdata_d = {16'h0, num_q};
                gear_clutch_pkg::REG_CUR_DEN:   rdata_d = {16'h0, den_q};
                default:                        rdata_d = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_q    <= 4'h0;
            in_t_q    <= gear_clutch_pkg::TEETH_RST;
            out_t_q   <= gear_clutch_pkg::TEETH_RST;
            smooth_q  <= gear_clutch_pkg::SMOOTH_RST;
            smeth_q   <= gear_clutch_pkg::SM_TIME;
            axes_q    <= gear_clutch_pkg::AXES_RST;
            reg_rdata <= 32'h0000_0000;
        end else begin
            ctrl_q    <= ctrl_d;
            in_t_q    <= in_t_d;
            out_t_q   <= out_t_d;
            smooth_q  <= smooth_d;
            smeth_q   <= smeth_d;
            axes_q    <= axes_d;
            reg_rdata <= rdata_d;
        end
    end

    // operation cycle timer; a new axis count applies at once, to the cycle already running
    always_comb begin
        period = cycle_clks(axes_q);
        tick   = virt_q && (tmr_q >= period - 32'h1);
        tmr_d  = (!virt_q || tick) ? 32'h0 : tmr_q + 32'h1;
    end

    // parameter capture: entry takes everything, cycles take the clutch command
    always_comb begin
        virt_d  = ctrl_q[gear_clutch_pkg::CTRL_VIRTUAL];
        den_d   = den_q;
        num_d   = num_q;
        rev_d   = rev_q;
        cmd_d   = cmd_q;
        stype_d = stype_q;
        am_d    = am_q;
        aslip_d = aslip_q;
        if (virt_d && !virt_q) begin
            den_d   = in_t_q;
            num_d   = out_t_q;
            rev_d   = ctrl_q[gear_clutch_pkg::CTRL_REVERSE];
            cmd_d   = ctrl_q[gear_clutch_pkg::CTRL_CLUTCH];
            stype_d = ctrl_q[gear_clutch_pkg::CTRL_SMOOTH];
            am_d    = smeth_q;
            aslip_d = smooth_q;
        end else if (virt_q && drive_rebase) begin
            den_d = in_t_q;
            num_d = out_t_q;
        end
        if (virt_q && tick) begin
            cmd_d = ctrl_q[gear_clutch_pkg::CTRL_CLUTCH];
        end
    end

    // gear: scale with carried remainder, then apply direction
    always_comb begin
        prod   = 48'(drive_pulses) * $signed({1'b0, num_q}) + acc_q;
        quot   = prod / $signed({1'b0, den_q});
        rem    = prod - quot * $signed({1'b0, den_q});
        geared = rev_q ? -quot[31:0] : quot[31:0];
        if (!rev_q) geared = quot[31:0];
        acc_d  = acc_q;
        if (!virt_q) acc_d = '0;
        else if (tick && fin_ready) acc_d = rem;
    end

    // clutch: direct switches at once, smoothing passes about half the geared travel each cycle until the slippage runs out
    always_comb begin
        clst_d  = clst_q;
        sdone_d = sdone_q;
        slip_d  = slip_q;
        clout   = 32'sh0;
        if (!virt_q) begin
            clst_d  = 1'b0;
            sdone_d = 1'b1;
            slip_d  = 32'sh0;
        end else if (tick) begin
            // the command sampled at this cycle end applies at once, even if the buffer drops the word
            clst_d = cmd_d;
            if (cmd_d != clst_q) begin
                sdone_d = !stype_q;
                slip_d  = 32'(aslip_q);
            end
            if (!stype_q) begin
                clout = cmd_d ? geared : 32'sh0;
            end else if (slip_q == 32'sh0 || sdone_q) begin
                clout = cmd_d ? geared : 32'sh0;
            end else begin
                case (am_q)
                    gear_clutch_pkg::SM_LINEAR: begin
                        // fixed step ramp over the slippage count
                        clout  = cmd_d ? geared / 32'sh2 : geared / 32'sh2;
                        slip_d = slip_q - 32'sh1;
                    end
                    gear_clutch_pkg::SM_EXP: begin
                        // halve the remaining slippage each cycle
                        clout  = cmd_d ? geared - (geared >>> 1) : (geared >>> 1);
                        slip_d = slip_q >>> 1;
                    end
                    default: begin
                        // time constant: remaining count decays by one
                        clout  = cmd_d ? geared >>> 1 : geared - (geared >>> 1);
                        slip_d = slip_q - 32'sh1;
                    end
                endcase
                if (slip_d <= 32'sh0) sdone_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tmr_q <= 32'h0;
            virt_q <= 1'b0;
            den_q <= gear_clutch_pkg::TEETH_RST;
            num_q <= gear_clutch_pkg::TEETH_RST;
            rev_q <= 1'b0;
            cmd_q <= 1'b0;
            stype_q <= 1'b0;
            am_q <= gear_clutch_pkg::SM_TIME;
            aslip_q <= gear_clutch_pkg::SMOOTH_RST;
            acc_q <= '0;
            clst_q <= 1'b0;
            sdone_q <= 1'b1;
            slip_q <= 32'sh0;
            cycle_tick <= 1'b0;
            clutch_status <= 1'b0;
            smooth_done <= 1'b1;
        end else begin
            tmr_q <= tmr_d;
            virt_q <= virt_d;
            den_q <= den_d;
            num_q <= num_d;
            rev_q <= rev_d;
            cmd_q <= cmd_d;
            stype_q <= stype_d;
            am_q <= am_d;
            aslip_q <= aslip_d;
            acc_q <= acc_d;
            clst_q <= clst_d;
            sdone_q <= sdone_d;
            slip_q <= slip_d;
            cycle_tick <= tick;
            clutch_status <= clst_d;
            smooth_done <= sdone_d;
        end
    end

    // output buffer; a full buffer drops the cycle's travel
    pulse_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_data   (clout),
        .in_valid  (tick),
        .in_ready  (fin_ready),
        .out_data  (fout),
        .out_valid (fvalid),
        .out_ready (out_ready && !(out_valid && !out_ready))
    );
    // registered output stage
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            out_pulses <= 32'sh0;
            out_valid  <= 1'b0;
        end else if (!out_valid || out_ready) begin
            out_pulses <= fout;
            out_valid  <= fvalid && out_ready;
        end
    end

    entry_capture_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($rose(virt_q)) |-> (den_q == $past(in_t_q) || $past(drive_rebase))) else $error("teeth not captured");
    teeth_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (virt_q && $past(virt_q) && !$past(drive_rebase)) |-> $stable(num_q)) else $error("teeth changed");
    status_tick_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($past(virt_q) && !$past(tick)) |-> $stable(clutch_status)) else $error("status off cycle");
    teeth_nonzero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        den_q != 16'h0000 && in_t_q != 16'h0000) else $error("zero teeth");
    cycle_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tick |-> tmr_q == period - 32'h1) else $error("cycle length");
    block_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (tick && !stype_q && !cmd_d) |-> clout == 32'sh0) else $error("pulses leaked");
    pass_on_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (tick && fin_ready && !stype_q && cmd_d) |-> clout == geared) else $error("pulses lost");
    dir_rev_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rev_q |-> geared == -quot[31:0]) else $error("direction wrong");
endmodule
`default_nettype wire

// File: rtl/pulse_fifo.sv
`default_nettype none
module pulse_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("pulse_fifo: bad depth or width");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // pointer and fill count next values
    always_comb begin
        push     = in_valid && (cnt_q != (AW+1)'(DEPTH));
        pop      = out_ready && (cnt_q != '0);
        wp_d     = push ? wp_q + AW'(1) : wp_q;
        rp_d     = pop ? rp_q + AW'(1) : rp_q;
        cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        in_ready = cnt_q != (AW+1)'(DEPTH);
        out_valid= cnt_q != '0;
        out_data = mem_q[rp_q];
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end
    // storage has no reset; only written words are ever read
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
    count_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count over depth");
endmodule
`default_nettype wire

// File: test/gear_clutch_bench.sv
`default_nettype none
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module gear_clutch_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CYC = 40; // shortened long operation cycle, keeps the run brief
    logic               clk_sys = 1'b0;
    logic               sys_rst = 1'b1;
    logic [3:0]         reg_addr = 4'h0;
    logic [31:0]        reg_wdata = 32'h0;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [31:0]        reg_rdata;
    logic signed [31:0] drive_pulses;
    logic               drive_rebase = 1'b0;
    logic signed [31:0] out_pulses;
    logic               out_valid;
    logic               out_ready;
    logic               cycle_tick;
    logic               clutch_status;
    logic               smooth_done;
    logic signed [31:0] travel = 32'sh0;
    logic               stall = 1'b0;
    logic [31:0]        rs = 32'h3C;
    logic [1:0]         meth[3] = '{gear_clutch_pkg::SM_TIME, gear_clutch_pkg::SM_EXP, gear_clutch_pkg::SM_LINEAR};
    int                 mismatches = 0;
    int                 checks_done = 0;
    int                 exp_q[$];
    int                 num = 1;
    int                 den = 1;
    int                 rem = 0;
    bit                 virt, clu, rev;

    // free-running system clock
    always #5 clk_sys = ~clk_sys;

    gear_clutch #(
        .FIFO_DEPTH (16),
        .CYC4_CLKS  (CYC)
    ) gear_clutch_inst (
        .clk_sys       (clk_sys),
        .sys_rst       (sys_rst),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .drive_pulses  (drive_pulses),
        .drive_rebase  (drive_rebase),
        .out_pulses    (out_pulses),
        .out_valid     (out_valid),
        .out_ready     (out_ready),
        .cycle_tick    (cycle_tick),
        .clutch_status (clutch_status),
        .smooth_done   (smooth_done)
    );

    pulse_partner pulse_partner_inst (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .travel       (travel),
        .stall        (stall),
        .out_pulses   (out_pulses),
        .out_valid    (out_valid),
        .drive_pulses (drive_pulses),
        .out_ready    (out_ready)
    );

    // odd values only, so every word is nonzero and can be counted
    function automatic int rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return (int'(rs & 32'h3FE) | 1) - 512;
    endfunction

    task automatic results();
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    task automatic tick_wait(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (cycle_tick !== 1'b1 && n < 200);
        if (n >= 200) mismatches++;
    endtask

    task automatic setc(input bit v, input bit c, input bit r, input bit s);
        logic [31:0] w;
        w = 32'h0;
        w[gear_clutch_pkg::CTRL_VIRTUAL] = v;
        w[gear_clutch_pkg::CTRL_CLUTCH]  = c;
        w[gear_clutch_pkg::CTRL_REVERSE] = r;
        w[gear_clutch_pkg::CTRL_SMOOTH]  = s;
        wr(gear_clutch_pkg::REG_CTRL, w);
        virt = v;
        clu  = c;
        rev  = r;
        if (!v) rem = 0; // real mode clears the carried remainder
    endtask

    // one operation cycle: reference gear keeps the remainder even while blocked
    task automatic cyc(input int v);
        int n, acc, o;
        travel = v;
        tick_wait(n);
        if (virt) begin
            acc = rem + v * num;
            o   = acc / den;
            rem = acc - o * den;
            if (rev) o = -o;
            if (clu && o != 0) exp_q.push_back(o);
        end
    endtask

    task automatic clear();
        exp_q.delete();
        pulse_partner_inst.rx_q.delete();
    endtask

    task automatic settle();
        int i;
        repeat (3) cyc(0);
        `CHK(pulse_partner_inst.rx_q.size(), exp_q.size())
        for (i = 0; i < exp_q.size() && i < pulse_partner_inst.rx_q.size(); i++) begin
            `CHK(pulse_partner_inst.rx_q[i], 32'(exp_q[i]))
        end
        clear();
    endtask

    // main sequence
    initial begin
        int n, i, m, k;
        bit lo, hi;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rchk(gear_clutch_pkg::REG_IN_TEETH, 32'h1);
        rchk(gear_clutch_pkg::REG_OUT_TEETH, 32'h1);
        rchk(gear_clutch_pkg::REG_SMOOTH, 32'h4);
        rchk(gear_clutch_pkg::REG_AXES, 32'h1);
        rchk(gear_clutch_pkg::REG_STATUS, 32'h2);
        wr(4'hF, 32'hFFFF_FFFF);
        rchk(gear_clutch_pkg::REG_CTRL, 32'h0);
        // smallest axis count of the longest period band, then a refused zero
        wr(gear_clutch_pkg::REG_AXES, 32'h1D);
        setc(1'b1, 1'b0, 1'b0, 1'b0);
        tick_wait(n);
        tick_wait(n);
        `CHK(n, CYC)
        wr(gear_clutch_pkg::REG_AXES, 32'h0);
        tick_wait(n);
        tick_wait(n);
        `CHK(n, CYC)
        rchk(gear_clutch_pkg::REG_AXES, 32'h1D);
        // direct clutch engaged, forward, default ratio
        setc(1'b1, 1'b1, 1'b0, 1'b0);
        repeat (6) cyc(rnd());
        settle();
        setc(1'b1, 1'b0, 1'b0, 1'b0);
        `CHK(clutch_status, 1'b1)
        cyc(rnd());
        `CHK(clutch_status, 1'b0)
        repeat (4) cyc(rnd());
        settle();
        // direction is taken only on entry to virtual mode
        setc(1'b0, 1'b1, 1'b1, 1'b0);
        setc(1'b1, 1'b1, 1'b1, 1'b0);
        repeat (6) cyc(rnd());
        settle();
        // output axis stalls long enough to overflow the buffer
        setc(1'b0, 1'b1, 1'b0, 1'b0);
        setc(1'b1, 1'b1, 1'b0, 1'b0);
        stall = 1'b1;
        repeat (20) cyc(rnd());
        stall = 1'b0;
        repeat (3) cyc(0);
        n = pulse_partner_inst.rx_q.size();
        `CHK(n >= 16 && n <= 18, 1'b1)
        for (i = 0; i < 16; i++) begin
            `CHK(pulse_partner_inst.rx_q[i], 32'(exp_q[i]))
        end
        clear();
        // tooth counts load only on rebase or on entry to virtual mode
        wr(gear_clutch_pkg::REG_IN_TEETH, 32'h7);
        wr(gear_clutch_pkg::REG_OUT_TEETH, 32'h3);
        wr(gear_clutch_pkg::REG_IN_TEETH, 32'h0);
        rchk(gear_clutch_pkg::REG_CUR_NUM, 32'h1);
        @(posedge clk_sys);
        drive_rebase <= 1'b1;
        @(posedge clk_sys);
        drive_rebase <= 1'b0;
        rchk(gear_clutch_pkg::REG_CUR_NUM, 32'h3);
        rchk(gear_clutch_pkg::REG_CUR_DEN, 32'h7);
        setc(1'b0, 1'b1, 1'b0, 1'b0);
        wr(gear_clutch_pkg::REG_OUT_TEETH, 32'h5);
        rchk(gear_clutch_pkg::REG_CUR_NUM, 32'h3);
        setc(1'b1, 1'b1, 1'b0, 1'b0);
        rchk(gear_clutch_pkg::REG_CUR_NUM, 32'h5);
        num = 5;
        den = 7;
        rem = 0;
        tick_wait(n);
        repeat (12) cyc(rnd());
        settle();
        // each smoothing method must drop and then raise its done flag
        for (m = 0; m < 3; m++) begin
            wr(gear_clutch_pkg::REG_SMOOTH, {14'h0, meth[m], 16'h0004});
            // clutch type and smoothing settings are taken only on entry
            setc(1'b0, 1'b0, 1'b0, 1'b1);
            setc(1'b1, 1'b0, 1'b0, 1'b1);
            cyc(0);
            setc(1'b1, 1'b1, 1'b0, 1'b1);
            clu = 1'b0; // ramped words are not modelled
            lo  = 1'b0;
            hi  = 1'b0;
            for (k = 0; k < 30; k++) begin
                cyc(100);
                if (smooth_done === 1'b0) lo = 1'b1;
                if (lo && smooth_done === 1'b1) hi = 1'b1;
            end
            `CHK({lo, hi}, 2'h3)
            setc(1'b1, 1'b0, 1'b0, 1'b1);
            repeat (30) cyc(0);
            clear();
        end
        results();
    end

    // watchdog well beyond the few hundred operation cycles above
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        results();
    end
endmodule
`default_nettype wire

// File: test/pulse_partner.sv
`default_nettype none
module pulse_partner (
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    input  wire logic signed [31:0] travel,
    input  wire logic               stall,
    input  wire logic signed [31:0] out_pulses,
    input  wire logic               out_valid,
    output logic signed [31:0]      drive_pulses,
    output logic                    out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic signed [31:0] rx_q[$]; // nonzero words taken by the output axis

    // drive source follows the commanded travel, registered so it never moves mid-edge
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            drive_pulses <= 32'sh0;
        end else begin
            drive_pulses <= travel;
        end
    end

    // output axis takes words unless stalled; zero words carry no travel, so skip them
    always @(posedge clk_sys) begin
        out_ready <= !stall && !sys_rst;
        if (out_valid === 1'b1 && out_ready && out_pulses !== 32'sh0) begin
            rx_q.push_back(out_pulses);
        end
    end
endmodule
`default_nettype wire
